/* verilog/cvsg_map.svh */
`ifndef CVSG_MAP_SVH
`define CVSG_MAP_SVH

// widths and counts
`define CVSG_POS_W        13
`define CVSG_REP_W        12
`define CVSG_SEL_W        5
`define CVSG_GRP_N        32
`define CVSG_OUT_N        13
`define CVSG_TOG_N        6
`define CVSG_ASSIGN_W     12
`define CVSG_ADDR_W       13
`define CVSG_POS_IGNORE_LO 13'h0000
`define CVSG_POS_IGNORE_HI 13'h1fff

// address map: bit 12 clear selects pattern storage
`define CVSG_ADDR_SEQ_BIT 12
`define CVSG_ADDR_GRP_HI  11
`define CVSG_ADDR_GRP_LO  7
`define CVSG_ADDR_OUT_HI  6
`define CVSG_ADDR_OUT_LO  3
`define CVSG_ADDR_TOG_HI  2
`define CVSG_ADDR_TOG_LO  0

// sequence register indices (low five address bits)
`define CVSG_IDX_HOLD       5'h00
`define CVSG_IDX_MASK_MODE  5'h01
`define CVSG_IDX_LINE_LEN   5'h02
`define CVSG_IDX_POLARITY   5'h03
`define CVSG_IDX_ASSIGN     5'h04
`define CVSG_IDX_COMBINE    5'h05
`define CVSG_IDX_SEL_A      5'h06
`define CVSG_IDX_SEL_B      5'h07
`define CVSG_IDX_ALT_MODE   5'h08
`define CVSG_IDX_START_A    5'h09
`define CVSG_IDX_START_B    5'h0a
`define CVSG_IDX_LEN_A      5'h0b
`define CVSG_IDX_LEN_B      5'h0c
`define CVSG_IDX_REPB_ODD   5'h0d
`define CVSG_IDX_REPB_EVEN  5'h0e
`define CVSG_IDX_REPA_1     5'h0f
`define CVSG_IDX_REPA_2     5'h10
`define CVSG_IDX_REPA_3     5'h11
`define CVSG_IDX_REPA_4     5'h12
`define CVSG_IDX_STOP_1     5'h13
`define CVSG_IDX_CONT_1     5'h14
`define CVSG_IDX_STOP_2     5'h15
`define CVSG_IDX_CONT_2     5'h16
`define CVSG_IDX_INS_LINE   5'h17
`define CVSG_IDX_INS_EN     5'h18
`define CVSG_IDX_LAST_LEN   5'h19
`define CVSG_IDX_STAT_PIX   5'h1a
`define CVSG_IDX_STAT_LINE  5'h1b

// reset values
`define CVSG_RST_LINE_LEN   13'h0000
`define CVSG_RST_LAST_LEN   13'h0000

`endif

/* verilog/cvsg_pkg.sv */
package cvsg_pkg;
`include "cvsg_map.svh"

    typedef enum logic {
        CVSG_ENG_IDLE = 1'b0,
        CVSG_ENG_RUN  = 1'b1
    } cvsg_eng_state_t;

    typedef logic [`CVSG_OUT_N-1:0][`CVSG_TOG_N-1:0][`CVSG_POS_W-1:0]
        cvsg_group_t;

    typedef struct packed {
        cvsg_eng_state_t        st;
        logic [`CVSG_POS_W-1:0] phase;
        logic [`CVSG_REP_W-1:0] remain;
    } cvsg_eng_t;

    typedef struct packed {
        logic [`CVSG_GRP_N-1:0][`CVSG_OUT_N-1:0][`CVSG_TOG_N-1:0]
            [`CVSG_POS_W-1:0]         tog;
        logic                         hold;
        logic [1:0]                   maskMode;
        logic [`CVSG_POS_W-1:0]       lineLen;
        logic [`CVSG_OUT_N-1:0]       pol;
        logic [`CVSG_ASSIGN_W-1:0]    grpAssign;
        logic                         combine;
        logic [`CVSG_SEL_W-1:0]       selA;
        logic [`CVSG_SEL_W-1:0]       selB;
        logic [1:0]                   altMode;
        logic [`CVSG_POS_W-1:0]       startA;
        logic [`CVSG_POS_W-1:0]       startB;
        logic [`CVSG_POS_W-1:0]       lenA;
        logic [`CVSG_POS_W-1:0]       lenB;
        logic [`CVSG_REP_W-1:0]       repBOdd;
        logic [`CVSG_REP_W-1:0]       repBEven;
        logic [3:0][`CVSG_REP_W-1:0]  repA;
        logic [`CVSG_POS_W-1:0]       stop1;
        logic [`CVSG_POS_W-1:0]       cont1;
        logic [`CVSG_POS_W-1:0]       stop2;
        logic [`CVSG_POS_W-1:0]       cont2;
        logic [`CVSG_REP_W-1:0]       insLine;
        logic                         insEn;
        logic [`CVSG_POS_W-1:0]       lastLen;
        logic [`CVSG_POS_W-1:0]       hCount;
        logic [`CVSG_REP_W-1:0]       lineCount;
        logic [1:0]                   altPhase;
        logic [`CVSG_OUT_N-1:0]       vOut;
        logic [`CVSG_POS_W-1:0]       rdData;
        logic                         rdValid;
    } cvsg_state_t;
endpackage

/* verilog/cvsg_pattern_engine.sv */
// walks one pattern group: phase within the pattern and repetitions left
module cvsg_pattern_engine
    import cvsg_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   ce,
    input  wire logic                   lineStart,
    input  wire logic                   trigger,
    input  wire logic                   stall,
    input  wire logic [`CVSG_POS_W-1:0] patLen,
    input  wire logic [`CVSG_REP_W-1:0] reps,
    output logic      [`CVSG_POS_W-1:0] phase,
    output logic                        running
);
    cvsg_eng_t eng_r;
    cvsg_eng_t eng_nxt;
    logic [`CVSG_POS_W-1:0] lastPhase;

    // a length of zero wraps to a full 8192-pixel pattern
    assign lastPhase = patLen - 13'h0001;

    // trigger wins over the line-start clear, since both can meet at pixel 0
    always_comb begin
        eng_nxt = eng_r;
        if (trigger && reps != 12'h000) begin
            eng_nxt.st     = CVSG_ENG_RUN;
            eng_nxt.phase  = 13'h0000;
            eng_nxt.remain = reps;
        end else if (lineStart) begin
            eng_nxt.st = CVSG_ENG_IDLE;
        end else if (eng_r.st == CVSG_ENG_RUN && !stall) begin
            if (eng_r.phase == lastPhase) begin
                eng_nxt.phase = 13'h0000;
                if (eng_r.remain > 12'h001) begin
                    eng_nxt.remain = eng_r.remain - 12'h001;
                end else begin
                    eng_nxt.st = CVSG_ENG_IDLE;
                end
            end else begin
                eng_nxt.phase = eng_r.phase + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            eng_r <= '0;
        end else if (ce) begin
            eng_r <= eng_nxt;
        end
    end

    assign phase   = eng_r.phase;
    assign running = (eng_r.st == CVSG_ENG_RUN);
endmodule // cvsg_pattern_engine

/* verilog/cvsg_toggle_match.sv */
// flags the outputs whose toggle list holds the current phase
module cvsg_toggle_match
    import cvsg_pkg::*;
(
    input  wire cvsg_group_t            group,
    input  wire logic [`CVSG_POS_W-1:0] phase,
    output logic      [`CVSG_OUT_N-1:0] hit
);
    // pixel 0 and the top pixel are parking values for unused channels
    function automatic logic isLiveToggle(input logic [`CVSG_POS_W-1:0] p);
        isLiveToggle = (p != `CVSG_POS_IGNORE_LO) &&
                       (p != `CVSG_POS_IGNORE_HI);
    endfunction

    // six comparators per output, ored together
    always_comb begin
        hit = '0;
        for (int o = 0; o < `CVSG_OUT_N; o++) begin
            for (int t = 0; t < `CVSG_TOG_N; t++) begin
                if (isLiveToggle(group[o][t]) && group[o][t] == phase) begin
                    hit[o] = 1'b1;
                end
            end
        end
    end
endmodule // cvsg_toggle_match

/* verilog/ccd_vertical_sequence_generator.sv */
// Notes on behaviour
// - each pattern group has six 13-bit toggle positions per output
// - toggle positions at pixel 0 or 8191 never cause a transition
// - each of thirteen outputs has a start level before its first toggle
// - two 5-bit selectors pick pattern groups A and B out of 32
// - a per-output bit assigns the first twelve outputs to group A or group B
// - combine bit makes every output use A and B toggles together
// - when combined, length, start pixel and repeats come from group A
// - groups A and B each have a 13-bit start pixel in the line
// - groups A and B each have a 13-bit pattern length in pixels
// - four 12-bit group A repeat counts for lines one to four
// - group A mode picks one, two, three or four-line repeat cycling
// - group B has 12-bit repeat counts for odd and even lines
// - 2-bit mask mode enables none, first, second or both mask pairs
// - mask pairs give 13-bit stop and continue pixels for outputs
// - hold bit with masking turns a mask pair into a hold region
// - hold resumes where it stopped; group B outputs ignore the hold
// - sequence line length sets the pixel counter wrap, up to 8192
// - the field's last line uses its own pixel count instead
// - insertion adds group B pattern at B start on the chosen line
module ccd_vertical_sequence_generator
    import cvsg_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    ce,
    input  wire logic                    fieldStart,
    input  wire logic                    lastLine,
    input  wire logic                    regWrite,
    input  wire logic                    regRead,
    input  wire logic [`CVSG_ADDR_W-1:0] regAddr,
    input  wire logic [`CVSG_POS_W-1:0]  regWriteData,
    output logic      [`CVSG_POS_W-1:0]  regReadData,
    output logic                         regReadValid,
    output logic      [`CVSG_OUT_N-1:0]  verticalClockOutputs
);
    cvsg_state_t st_r;
    cvsg_state_t st_nxt;

    logic [`CVSG_POS_W-1:0] phaseA;
    logic [`CVSG_POS_W-1:0] phaseB;
    logic                   runA;
    logic                   runB;
    logic [`CVSG_OUT_N-1:0] matchA;
    logic [`CVSG_OUT_N-1:0] matchB;
    logic [`CVSG_POS_W-1:0] phaseForB;
    logic [`CVSG_POS_W-1:0] lineEnd;
    logic                   wrap;
    logic [`CVSG_POS_W-1:0] hNext;
    logic [`CVSG_REP_W-1:0] lineNext;
    logic [1:0]             altNext;
    logic                   insertNext;
    logic                   insertNow;
    logic [`CVSG_REP_W-1:0] repsA;
    logic [`CVSG_REP_W-1:0] repsB;
    logic [`CVSG_POS_W-1:0] lenB;
    logic                   trigA;
    logic                   trigB;
    logic                   masked;
    logic                   stallA;
    logic                   stallB;

    // half-open window test, shared by both mask pairs
    function automatic logic inWindow(input logic [`CVSG_POS_W-1:0] p,
                                      input logic [`CVSG_POS_W-1:0] lo,
                                      input logic [`CVSG_POS_W-1:0] hi);
        inWindow = (p >= lo) && (p < hi);
    endfunction

    // pixel and line counting; the last line of a field is cut short
    always_comb begin
        lineEnd = lastLine ? st_r.lastLen : st_r.lineLen;
        // a length of zero wraps after the full 8192 pixels
        wrap  = fieldStart ||
                (st_r.hCount == lineEnd - 13'h0001);
        hNext = wrap ? 13'h0000 : st_r.hCount + 13'h0001;
        if (fieldStart) begin
            lineNext = 12'h000;
            altNext  = 2'h0;
        end else if (wrap) begin
            lineNext = st_r.lineCount + 12'h001;
            altNext  = (st_r.altPhase >= st_r.altMode) ? 2'h0
                     : st_r.altPhase + 2'h1;
        end else begin
            lineNext = st_r.lineCount;
            altNext  = st_r.altPhase;
        end
    end

    // repeat counts for the line that the next pixel belongs to
    always_comb begin
        repsA      = st_r.repA[altNext];
        insertNext = st_r.insEn && (lineNext == st_r.insLine);
        insertNow  = st_r.insEn && (st_r.lineCount == st_r.insLine);
        // line 0 is the first, odd line of the field
        if (insertNext) begin
            repsB = 12'h001;
        end else if (lineNext[0] == 1'b0) begin
            repsB = st_r.repBOdd;
        end else begin
            repsB = st_r.repBEven;
        end
        lenB  = st_r.lenB;
        trigA = (hNext == st_r.startA);
        trigB = (hNext == st_r.startB) && !st_r.combine;
    end

    // masking: plain mask freezes every output, hold stalls group A only
    always_comb begin
        masked = (st_r.maskMode[0] &&
                  inWindow(st_r.hCount, st_r.stop1, st_r.cont1)) ||
                 (st_r.maskMode[1] &&
                  inWindow(st_r.hCount, st_r.stop2, st_r.cont2));
        stallA = masked && st_r.hold;
        stallB = 1'b0;
    end

    cvsg_pattern_engine engA (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .lineStart (wrap),
        .trigger   (trigA),
        .stall     (stallA),
        .patLen    (st_r.lenA),
        .reps      (repsA),
        .phase     (phaseA),
        .running   (runA)
    );

    cvsg_pattern_engine engB (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .lineStart (wrap),
        .trigger   (trigB),
        .stall     (stallB),
        .patLen    (lenB),
        .reps      (repsB),
        .phase     (phaseB),
        .running   (runB)
    );

    // combined groups read the B toggles against the A phase
    assign phaseForB = st_r.combine ? phaseA : phaseB;

    cvsg_toggle_match matchGroupA (
        .group (st_r.tog[st_r.selA]),
        .phase (phaseA),
        .hit   (matchA)
    );

    cvsg_toggle_match matchGroupB (
        .group (st_r.tog[st_r.selB]),
        .phase (phaseForB),
        .hit   (matchB)
    );

    // register file, counters and output levels
    always_comb begin
        logic              useB;
        logic              hitA;
        logic              hitB;
        logic              flip;
        logic [`CVSG_OUT_N-1:0] assignAll;
        useB     = 1'b0;
        hitA     = 1'b0;
        hitB     = 1'b0;
        flip     = 1'b0;
        // the last output has no assignment bit, so it reads as group A
        assignAll = {1'b0, st_r.grpAssign};
        st_nxt   = st_r;
        st_nxt.rdValid = 1'b0;

        // writes: pattern storage below bit 12, sequence registers above
        if (regWrite) begin
            if (!regAddr[`CVSG_ADDR_SEQ_BIT]) begin
                // output and toggle indices past the last are dropped
                if (regAddr[`CVSG_ADDR_OUT_HI:`CVSG_ADDR_OUT_LO] < 4'hd &&
                    regAddr[`CVSG_ADDR_TOG_HI:`CVSG_ADDR_TOG_LO] < 3'h6) begin
                    st_nxt.tog[regAddr[`CVSG_ADDR_GRP_HI:`CVSG_ADDR_GRP_LO]]
                              [regAddr[`CVSG_ADDR_OUT_HI:`CVSG_ADDR_OUT_LO]]
                              [regAddr[`CVSG_ADDR_TOG_HI:`CVSG_ADDR_TOG_LO]]
                        = regWriteData;
                end
            end else begin
                case (regAddr[4:0])
                    `CVSG_IDX_HOLD:      st_nxt.hold = regWriteData[0];
                    `CVSG_IDX_MASK_MODE: st_nxt.maskMode = regWriteData[1:0];
                    `CVSG_IDX_LINE_LEN:  st_nxt.lineLen = regWriteData;
                    `CVSG_IDX_POLARITY:  st_nxt.pol = regWriteData;
                    `CVSG_IDX_ASSIGN:    st_nxt.grpAssign = regWriteData[11:0];
                    `CVSG_IDX_COMBINE:   st_nxt.combine = regWriteData[0];
                    `CVSG_IDX_SEL_A:     st_nxt.selA = regWriteData[4:0];
                    `CVSG_IDX_SEL_B:     st_nxt.selB = regWriteData[4:0];
                    `CVSG_IDX_ALT_MODE:  st_nxt.altMode = regWriteData[1:0];
                    `CVSG_IDX_START_A:   st_nxt.startA = regWriteData;
                    `CVSG_IDX_START_B:   st_nxt.startB = regWriteData;
                    `CVSG_IDX_LEN_A:     st_nxt.lenA = regWriteData;
                    `CVSG_IDX_LEN_B:     st_nxt.lenB = regWriteData;
                    `CVSG_IDX_REPB_ODD:  st_nxt.repBOdd = regWriteData[11:0];
                    `CVSG_IDX_REPB_EVEN: st_nxt.repBEven = regWriteData[11:0];
                    `CVSG_IDX_REPA_1:    st_nxt.repA[0] = regWriteData[11:0];
                    `CVSG_IDX_REPA_2:    st_nxt.repA[1] = regWriteData[11:0];
                    `CVSG_IDX_REPA_3:    st_nxt.repA[2] = regWriteData[11:0];
                    `CVSG_IDX_REPA_4:    st_nxt.repA[3] = regWriteData[11:0];
                    `CVSG_IDX_STOP_1:    st_nxt.stop1 = regWriteData;
                    `CVSG_IDX_CONT_1:    st_nxt.cont1 = regWriteData;
                    `CVSG_IDX_STOP_2:    st_nxt.stop2 = regWriteData;
                    `CVSG_IDX_CONT_2:    st_nxt.cont2 = regWriteData;
                    `CVSG_IDX_INS_LINE:  st_nxt.insLine = regWriteData[11:0];
                    `CVSG_IDX_INS_EN:    st_nxt.insEn = regWriteData[0];
                    `CVSG_IDX_LAST_LEN:  st_nxt.lastLen = regWriteData;
                    default: ;
                endcase
            end
        end

        // reads answer one cycle later; unmapped indices read zero
        if (regRead) begin
            st_nxt.rdValid = 1'b1;
            if (!regAddr[`CVSG_ADDR_SEQ_BIT]) begin
                if (regAddr[`CVSG_ADDR_OUT_HI:`CVSG_ADDR_OUT_LO] < 4'hd &&
                    regAddr[`CVSG_ADDR_TOG_HI:`CVSG_ADDR_TOG_LO] < 3'h6) begin
                    st_nxt.rdData =
                        st_r.tog[regAddr[`CVSG_ADDR_GRP_HI:`CVSG_ADDR_GRP_LO]]
                                [regAddr[`CVSG_ADDR_OUT_HI:`CVSG_ADDR_OUT_LO]]
                                [regAddr[`CVSG_ADDR_TOG_HI:`CVSG_ADDR_TOG_LO]];
                end else begin
                    st_nxt.rdData = '0;
                end
            end else begin
                case (regAddr[4:0])
                    `CVSG_IDX_HOLD:      st_nxt.rdData = {12'h000, st_r.hold};
                    `CVSG_IDX_MASK_MODE: st_nxt.rdData = {11'h000, st_r.maskMode};
                    `CVSG_IDX_LINE_LEN:  st_nxt.rdData = st_r.lineLen;
                    `CVSG_IDX_POLARITY:  st_nxt.rdData = st_r.pol;
                    `CVSG_IDX_ASSIGN:    st_nxt.rdData = {1'b0, st_r.grpAssign};
                    `CVSG_IDX_COMBINE:   st_nxt.rdData = {12'h000, st_r.combine};
                    `CVSG_IDX_SEL_A:     st_nxt.rdData = {8'h00, st_r.selA};
                    `CVSG_IDX_SEL_B:     st_nxt.rdData = {8'h00, st_r.selB};
                    `CVSG_IDX_ALT_MODE:  st_nxt.rdData = {11'h000, st_r.altMode};
                    `CVSG_IDX_START_A:   st_nxt.rdData = st_r.startA;
                    `CVSG_IDX_START_B:   st_nxt.rdData = st_r.startB;
                    `CVSG_IDX_LEN_A:     st_nxt.rdData = st_r.lenA;
                    `CVSG_IDX_LEN_B:     st_nxt.rdData = st_r.lenB;
                    `CVSG_IDX_REPB_ODD:  st_nxt.rdData = {1'b0, st_r.repBOdd};
                    `CVSG_IDX_REPB_EVEN: st_nxt.rdData = {1'b0, st_r.repBEven};
                    `CVSG_IDX_REPA_1:    st_nxt.rdData = {1'b0, st_r.repA[0]};
                    `CVSG_IDX_REPA_2:    st_nxt.rdData = {1'b0, st_r.repA[1]};
                    `CVSG_IDX_REPA_3:    st_nxt.rdData = {1'b0, st_r.repA[2]};
                    `CVSG_IDX_REPA_4:    st_nxt.rdData = {1'b0, st_r.repA[3]};
                    `CVSG_IDX_STOP_1:    st_nxt.rdData = st_r.stop1;
                    `CVSG_IDX_CONT_1:    st_nxt.rdData = st_r.cont1;
                    `CVSG_IDX_STOP_2:    st_nxt.rdData = st_r.stop2;
                    `CVSG_IDX_CONT_2:    st_nxt.rdData = st_r.cont2;
                    `CVSG_IDX_INS_LINE:  st_nxt.rdData = {1'b0, st_r.insLine};
                    `CVSG_IDX_INS_EN:    st_nxt.rdData = {12'h000, st_r.insEn};
                    `CVSG_IDX_LAST_LEN:  st_nxt.rdData = st_r.lastLen;
                    `CVSG_IDX_STAT_PIX:  st_nxt.rdData = st_r.hCount;
                    `CVSG_IDX_STAT_LINE: st_nxt.rdData = {1'b0, st_r.lineCount};
                    default:             st_nxt.rdData = '0;
                endcase
            end
        end

        st_nxt.hCount    = hNext;
        st_nxt.lineCount = lineNext;
        st_nxt.altPhase  = altNext;

        // output levels; the last output has no assignment bit, so stays on A
        for (int o = 0; o < `CVSG_OUT_N; o++) begin
            useB = !st_r.combine && assignAll[o];
            hitA = runA && matchA[o];
            hitB = (st_r.combine ? runA : runB) && matchB[o];
            if (st_r.combine) begin
                flip = hitA || hitB;
            end else if (useB) begin
                flip = hitB;
            end else begin
                // the inserted pattern rides over the line's own pattern
                flip = hitA || (insertNow && hitB);
            end
            // a plain mask freezes all; a hold only freezes group A outputs
            if (masked && (!st_r.hold || !useB)) begin
                flip = 1'b0;
            end
            if (wrap) begin
                st_nxt.vOut[o] = st_r.pol[o];
            end else if (flip) begin
                st_nxt.vOut[o] = ~st_r.vOut[o];
            end
        end
    end

    // pattern storage resets to zero, which parks every toggle harmlessly
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r         <= '0;
            st_r.lineLen <= `CVSG_RST_LINE_LEN;
            st_r.lastLen <= `CVSG_RST_LAST_LEN;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign regReadData          = st_r.rdData;
    assign regReadValid         = st_r.rdValid;
    assign verticalClockOutputs = st_r.vOut;
endmodule // ccd_vertical_sequence_generator

/* bench/cvsg_monitor.sv */
module cvsg_monitor (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        ce,
    input wire logic        regRead,
    input wire logic [12:0] regAddr,
    input wire logic [12:0] regReadData,
    input wire logic        regReadValid,
    input wire logic [12:0] verticalClockOutputs
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // a read taken at this edge
    sequence rdTaken;
        ce && regRead && !reset;
    endsequence
    a_read_answer: assert property (rdTaken |=> regReadValid)
        else $error("read not answered");
    a_no_stray: assert property (ce && !regRead |=> !regReadValid)
        else $error("valid without read");
    a_data_holds: assert property (!(ce && regRead) && !reset
        |=> $stable(regReadData)) else $error("read data moved");
    a_out_range: assert property (rdTaken ##0
        (!regAddr[12] && regAddr[6:3] > 4'hc) |=> regReadData == 13'h0000)
        else $error("absent output read nonzero");
    a_tog_range: assert property (rdTaken ##0
        (!regAddr[12] && regAddr[2:0] > 3'h5) |=> regReadData == 13'h0000)
        else $error("absent toggle read nonzero");
    a_unmapped_zero: assert property (rdTaken ##0
        (regAddr[12] && regAddr[4:0] > 5'h1b) |=> regReadData == 13'h0000)
        else $error("unmapped read nonzero");
    // a stalled pixel clock must not move the phases
    a_stall_holds: assert property (!ce && !reset
        |=> $stable(verticalClockOutputs)) else $error("outputs moved");
    a_reset_low: assert property (disable iff (1'b0) reset && ce
        |=> verticalClockOutputs == 13'h0000) else $error("not reset");
endmodule // cvsg_monitor

bind ccd_vertical_sequence_generator cvsg_monitor u_mon (.clk(clk),
    .reset(reset), .ce(ce), .regRead(regRead), .regAddr(regAddr),
    .regReadData(regReadData), .regReadValid(regReadValid),
    .verticalClockOutputs(verticalClockOutputs));

/* bench/cvsg_ccd_model.sv */
// driver stage stand-in: counts rising edges of the first two phases
module cvsg_ccd_model (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        snap,
    input  wire logic [12:0] phases,
    output logic      [12:0] rises,
    output logic             risesValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] prev_r;
    logic [7:0]  cnt0_r;
    logic [4:0]  cnt1_r;
    // second phase sits in the top bits so a stray edge shows up
    always_ff @(posedge clk) begin
        prev_r <= phases;
        risesValid <= snap;
        rises <= {cnt1_r, cnt0_r};
        if (clr) begin
            cnt0_r <= 8'h00;
            cnt1_r <= 5'h00;
        end else begin
            cnt0_r <= cnt0_r + 8'(phases[0] & ~prev_r[0]);
            cnt1_r <= cnt1_r + 5'(phases[1] & ~prev_r[1]);
        end
    end
endmodule // cvsg_ccd_model

/* bench/ccd_vertical_sequence_generator_tb.sv */
module ccd_vertical_sequence_generator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, fieldStart = 1'b0;
    logic regWrite = 1'b0, regRead = 1'b0, clr = 1'b0, snap = 1'b0;
    logic lastLine = 1'b0;
    logic [12:0] regAddr = 13'h0000, regWriteData = 13'h0000;
    logic [12:0] regReadData, vco, rises, rnd;
    logic        regReadValid, risesValid;
    logic [12:0] expQ[$];
    int          error_cnt = 0;
    int          n_tests = 0;
    // rises over four lines for modes 0..3 with repeats 1,2,3,4
    int          altSum[4] = '{4, 6, 7, 10};
    always #5 clk = ~clk;
    ccd_vertical_sequence_generator u_dut (.clk(clk), .reset(reset),
        .ce(ce), .fieldStart(fieldStart), .lastLine(lastLine),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWriteData(regWriteData), .regReadData(regReadData),
        .regReadValid(regReadValid), .verticalClockOutputs(vco));
    cvsg_ccd_model u_ccd (.clk(clk), .clr(clr), .snap(snap), .phases(vco),
        .rises(rises), .risesValid(risesValid));
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [12:0] d);
        @(negedge clk);
        regWrite = 1'b1;
        regAddr = a;
        regWriteData = d;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, input logic [12:0] e);
        @(negedge clk);
        regRead = 1'b1;
        regAddr = a;
        expQ.push_back(e);
        @(negedge clk);
        regRead = 1'b0;
    endtask
    // first start parks the phases low, second starts counting four lines
    task automatic run(input logic [12:0] e);
        for (int i = 0; i < 2; i++) begin
            repeat (20) @(negedge clk);
            fieldStart = 1'b1;
            clr = 1'b1;
            @(negedge clk);
            fieldStart = 1'b0;
            clr = 1'b0;
        end
        repeat (127) @(negedge clk);
        expQ.push_back(e);
        snap = 1'b1;
        @(negedge clk);
        snap = 1'b0;
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // answers come back in request order
    always @(negedge clk) begin
        if (regReadValid === 1'b1) check(regReadData, expQ.pop_front());
        if (risesValid === 1'b1) check(rises, expQ.pop_front());
    end
    // the tests need about 2000 cycles; allow ten times that
    initial begin
        #200000;
        error_cnt++;
        test_done;
    end
    initial begin
        void'($urandom(19));
        repeat (6) @(negedge clk);
        reset = 1'b0;
        rnd = 13'($urandom);
        rd(13'h1002, 13'h0000);
        wr(13'h1006, {8'h00, rnd[4:0]});
        rd(13'h1006, {8'h00, rnd[4:0]});
        wr(13'h1003, rnd);
        rd(13'h1003, rnd);
        wr({1'b0, rnd[4:0], 4'h2, 3'h5}, rnd);
        rd({1'b0, rnd[4:0], 4'h2, 3'h5}, rnd);
        rd(13'h0068, 13'h0000);
        rd(13'h0006, 13'h0000);
        rd(13'h101f, 13'h0000);
        $display("register test done");
        wr(13'h1003, 13'h0000);
        wr(13'h1002, 13'h0020);
        wr(13'h1009, 13'h0002);
        wr(13'h100b, 13'h0004);
        wr(13'h1006, 13'h0001);
        wr(13'h0080, 13'h0001);
        wr(13'h0081, 13'h0003);
        wr(13'h0089, 13'h1fff);
        for (int k = 0; k < 4; k++) wr(13'h100f + 13'(k), 13'(k + 1));
        wr(13'h100d, 13'h0002);
        wr(13'h100e, 13'h0002);
        for (int m = 0; m < 4; m++) begin
            wr(13'h1008, 13'(m));
            run(13'(altSum[m]));
        end
        $display("alternation test done");
        wr(13'h1007, 13'h0001);
        wr(13'h100a, 13'h0002);
        wr(13'h100c, 13'h0004);
        wr(13'h1004, 13'h0001);
        run(13'h0008);
        wr(13'h1007, 13'h0000);
        wr(13'h1005, 13'h0001);
        run(13'h000a);
        wr(13'h1005, 13'h0000);
        wr(13'h1004, 13'h0000);
        wr(13'h1013, 13'h0001);
        wr(13'h1014, 13'h0014);
        wr(13'h1001, 13'h0001);
        run(13'h0000);
        wr(13'h1001, 13'h0002);
        run(13'h000a);
        wr(13'h1008, 13'h0000);
        wr(13'h1019, 13'h0010);
        lastLine = 1'b1;
        run(13'h0008);
        lastLine = 1'b0;
        wr(13'h1000, 13'h0001);
        wr(13'h1001, 13'h0001);
        run(13'h0004);
        wr(13'h1001, 13'h0000);
        wr(13'h1007, 13'h0001);
        wr(13'h100a, 13'h0014);
        wr(13'h1017, 13'h0002);
        wr(13'h1018, 13'h0001);
        run(13'h0005);
        $display("group and mask test done");
        ce = 1'b0;
        repeat (4) @(negedge clk);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        $display("freeze test done");
        check(13'(expQ.size()), 13'h0000);
        test_done;
    end
endmodule // ccd_vertical_sequence_generator_tb
